// file: lcdhif_top.sv
// host register port of a character lcd controller: command register,
// data transfer register, address counter and the memory sequencer
// assumes host inputs are synchronous to i_clk and i_strobe is one cycle
`timescale 1ns/1ps
`include "lcdhif_params.svh"
module lcdhif_top
  import lcdhif_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_strobe,
  input wire logic i_reg_choice_line,
  input wire logic i_read_not_write,
  input wire logic [7:0] i_wdata,
  input wire logic i_driver_order_strap,
  output logic [7:0] o_rdata,
  output logic o_busy_indicator,
  output logic o_driver_layout_b
);
  // ==========================================================
  // state
  lcdhif_state_t state_q, state_d; // sequencer
  logic [6:0] ac_q, ac_d; // address_counter
  lcdhif_mem_t sel_q, sel_d; // selected memory
  logic inc_q, inc_d; // 1 = count up
  logic [7:0] dtr_q, dtr_d; // data_transfer_reg
  logic [7:0] rdata_q, rdata_d; // host read data
  logic [8:0] cnt_q, cnt_d; // instruction execution timer
  logic layout_q, layout_d; // captured strap
  logic strap_done_q, strap_done_d; // strap already caught
  logic busy; // internal operation running
  logic cmd_wr, st_rd, dt_wr, dt_rd; // decoded host accesses

  lcdhif_ram_if ram ();

  lcdhif_mem u_mem (
    .i_clk(i_clk),
    .bus(ram)
  );

  // ==========================================================
  // next address: char memory wraps at its last row, others at 32
  function automatic logic [6:0] step_ac(input logic [6:0] ac,
      input logic up, input lcdhif_mem_t sel);
    logic [6:0] r;
    r = 7'h00;
    if (sel == MEM_CHAR) begin
      if (up) begin
        r = (ac >= `LCDHIF_CHAR_LAST) ? 7'h00 : ac + 7'h01;
      end else begin
        r = (ac == 7'h00) ? `LCDHIF_CHAR_LAST : ac - 7'h01;
      end
    end else begin
      r = {2'h0, up ? ac[4:0] + 5'h01 : ac[4:0] - 5'h01};
    end
    return r;
  endfunction : step_ac

  // ==========================================================
  // host access decode
  assign busy = (state_q != ST_IDLE);
  assign cmd_wr = i_strobe && !i_reg_choice_line && !i_read_not_write;
  assign st_rd = i_strobe && !i_reg_choice_line && i_read_not_write;
  assign dt_wr = i_strobe && i_reg_choice_line && !i_read_not_write;
  assign dt_rd = i_strobe && i_reg_choice_line && i_read_not_write;

  // memory port follows the counter; write only in ST_WRITE
  assign ram.addr = {sel_q, ac_q[5:0]};
  assign ram.wdata = dtr_q;
  assign ram.we = (state_q == ST_WRITE);

  // ==========================================================
  // sequencer next state; accesses other than status are dropped
  // while busy, so a host ignoring busy loses bytes rather than
  // corrupting a transfer in flight
  always_comb begin
    state_d = state_q;
    ac_d = ac_q;
    sel_d = sel_q;
    inc_d = inc_q;
    dtr_d = dtr_q;
    rdata_d = rdata_q;
    cnt_d = cnt_q;
    // status read works at any time; the command itself never shows
    if (st_rd) begin
      rdata_d = {busy, ac_q};
    end
    case (state_q)
      ST_IDLE: begin
        if (cmd_wr) begin
          if (i_wdata[`LCDHIF_CMD_CHAR_BIT]) begin
            ac_d = i_wdata[6:0];
            sel_d = MEM_CHAR;
            state_d = ST_FETCH;
          end else if (i_wdata[7:6] == `LCDHIF_CMD_GLYPH_CODE) begin
            ac_d = {2'h0, i_wdata[4:0]};
            sel_d = MEM_GLYPH;
            state_d = ST_FETCH;
          end else if (i_wdata[7:5] == `LCDHIF_CMD_ICON_CODE) begin
            ac_d = {2'h0, i_wdata[4:0]};
            sel_d = MEM_ICON;
            state_d = ST_FETCH;
          end else begin
            // other instructions occupy the device for a while; entry mode also sets the count direction
            if (i_wdata[7:2] == `LCDHIF_CMD_ENTRY_CODE) begin
              inc_d = i_wdata[`LCDHIF_CMD_INC_BIT];
            end
            cnt_d = 9'(`LCDHIF_EXEC_CYCLES - 1);
            state_d = ST_EXEC;
          end
        end else if (dt_wr) begin
          dtr_d = i_wdata;
          state_d = ST_WRITE;
        end else if (dt_rd) begin
          rdata_d = dtr_q;
          ac_d = step_ac(ac_q, inc_q, sel_q);
          state_d = ST_FETCH;
        end
      end
      ST_WRITE: begin
        // memory takes the byte at this edge, then the counter moves
        ac_d = step_ac(ac_q, inc_q, sel_q);
        state_d = ST_IDLE;
      end
      ST_FETCH: begin
        state_d = ST_CAPTURE; // memory registers its read data now
      end
      ST_CAPTURE: begin
        dtr_d = ram.rdata;
        state_d = ST_IDLE;
      end
      ST_EXEC: begin
        if (cnt_q == 9'h000) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 9'h001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ac_q <= `LCDHIF_AC_RST;
      sel_q <= MEM_CHAR;
      inc_q <= 1'b1;
      dtr_q <= `LCDHIF_DTR_RST;
      rdata_q <= `LCDHIF_RDATA_RST;
      cnt_q <= 9'h000;
    end else begin
      state_q <= state_d;
      ac_q <= ac_d;
      sel_q <= sel_d;
      inc_q <= inc_d;
      dtr_q <= dtr_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // strap capture: caught once, on the first edge after reset release,
  // so a strap that glitches later cannot reshuffle the drivers
  always_comb begin
    layout_d = layout_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      layout_d = i_driver_order_strap;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      layout_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      layout_q <= layout_d;
      strap_done_q <= strap_done_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_busy_indicator = busy;
  assign o_driver_layout_b = layout_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_status_read;
    st_rd |=> o_rdata == {$past(busy), $past(ac_q)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_data_write;
    (state_q == ST_IDLE) && dt_wr |=> ram.we && ram.wdata == $past(i_wdata)
      ##1 state_q == ST_IDLE && !ram.we;
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("written byte not stored");

  property p_addr_set;
    (state_q == ST_IDLE) && cmd_wr && i_wdata[7] |=>
      ac_q == $past(i_wdata[6:0]) && sel_q == MEM_CHAR
      ##2 state_q == ST_IDLE && dtr_q === $past(ram.rdata);
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("address set prefetch wrong");

  property p_host_read;
    (state_q == ST_IDLE) && dt_rd |=> o_rdata == $past(dtr_q)
      ##1 state_q == ST_CAPTURE ##1 dtr_q === $past(ram.rdata);
  endproperty
  a_host_read: assert property (p_host_read)
    else $error("read did not prefetch");

  property p_step;
    (state_q == ST_WRITE) && inc_q && (sel_q != MEM_CHAR) |=>
      ac_q[4:0] == $past(ac_q[4:0]) + 5'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step");

  property p_cmd_hidden;
    cmd_wr |=> $stable(o_rdata);
  endproperty
  a_cmd_hidden: assert property (p_cmd_hidden)
    else $error("command visible to host");

  property p_strap;
    $rose(strap_done_q) |-> layout_q == $past(i_driver_order_strap);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not captured");

  property p_exec_busy;
    (state_q == ST_IDLE) && cmd_wr && (i_wdata[7:5] == 3'h0) |=>
      o_busy_indicator [*8];
  endproperty
  a_exec_busy: assert property (p_exec_busy)
    else $error("busy dropped early");

  property p_ignore_busy;
    (state_q == ST_EXEC) && dt_wr |=> $stable(dtr_q) && !ram.we;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("access taken while busy");

  c_write: cover property ((state_q == ST_IDLE) && dt_wr);
  c_read: cover property ((state_q == ST_IDLE) && dt_rd ##3 dt_rd);
  c_glyph: cover property ((state_q == ST_IDLE) && cmd_wr
    && (i_wdata[7:6] == 2'h1));
  c_exec_end: cover property (state_q == ST_EXEC ##1 state_q == ST_IDLE);
endmodule : lcdhif_top

// file: lcdhif_params.svh
// constants of the lcd host register interface: field positions, resets,
// timing counts; included by the package users, holds definitions only
`ifndef LCDHIF_PARAMS_SVH
`define LCDHIF_PARAMS_SVH

// ==========================================================
// timing
`define LCDHIF_CLK_PERIOD_NS 100
`define LCDHIF_EXEC_TIME_NS 40000
`define LCDHIF_EXEC_CYCLES \
  ((`LCDHIF_EXEC_TIME_NS + `LCDHIF_CLK_PERIOD_NS - 1) / \
   `LCDHIF_CLK_PERIOD_NS)

// ==========================================================
// command byte layout
`define LCDHIF_CMD_CHAR_BIT 7
`define LCDHIF_CMD_GLYPH_CODE 2'h1
`define LCDHIF_CMD_ICON_CODE 3'h1
`define LCDHIF_CMD_ENTRY_CODE 6'h01
`define LCDHIF_CMD_INC_BIT 1

// ==========================================================
// memory sizes and reset values
`define LCDHIF_CHAR_LAST 7'h2F
`define LCDHIF_AC_RST 7'h00
`define LCDHIF_DTR_RST 8'h00
`define LCDHIF_RDATA_RST 8'h00

`endif

// file: lcdhif_pkg.sv
// types of the lcd host register interface
// assumes lcdhif_params.svh is on the include path
package lcdhif_pkg;
  // ==========================================================
  // control sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_FETCH = 3'b010,
    ST_CAPTURE = 3'b011,
    ST_EXEC = 3'b100
  } lcdhif_state_t;

  // ==========================================================
  // memory selected for data accesses
  typedef enum logic [1:0] {
    MEM_CHAR = 2'b00,
    MEM_GLYPH = 2'b01,
    MEM_ICON = 2'b10
  } lcdhif_mem_t;
endpackage : lcdhif_pkg

// file: lcdhif_ram_if.sv
// link between the control sequencer and the display memories
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lcdhif_ram_if;
  logic we; // write strobe, one cycle
  logic [7:0] addr; // {memory select, address counter}
  logic [7:0] wdata; // byte to store
  logic [7:0] rdata; // registered read data, one cycle latency
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : lcdhif_ram_if

// file: lcdhif_mem.sv
// the three display memories in one array, indexed by {select, address}
// assumes a single clock; read data come from a register
`timescale 1ns/1ps
module lcdhif_mem (
  input wire logic i_clk,
  lcdhif_ram_if.store bus
);
  // ==========================================================
  // storage; glyph and icon rows keep all 8 bits for simplicity
  logic [7:0] mem_q [0:255];
  logic [7:0] rdata_q;

  // write port and registered read port
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
    rdata_q <= mem_q[bus.addr];
  end

  assign bus.rdata = rdata_q;
endmodule : lcdhif_mem

// file: lcdhif_host_model.sv
// host processor model for the lcd host register port
// assumes the port samples its inputs on the rising edge of i_clk
`timescale 1ns/1ps
module lcdhif_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_busy_indicator,
  output logic o_strobe,
  output logic o_reg_choice_line,
  output logic o_read_not_write,
  output logic [7:0] o_wdata
);
  logic [7:0] rd_last; // byte returned by the latest access
  int wait_cnt; // bounded busy poll
  int poll_fail = 0; // polls that ran out while still busy

  // ==========================================================
  // idle bus at time zero
  initial begin
    o_strobe = 1'b0;
    o_reg_choice_line = 1'b0;
    o_read_not_write = 1'b1;
    o_wdata = 8'h00;
    rd_last = 8'h00;
  end

  // ==========================================================
  // one access, launched at a falling edge; only a status read may
  // go out while busy, so every other access waits for idle first
  task automatic access(input logic rs, input logic rw,
                        input logic [7:0] d);
    wait_cnt = 0;
    @(negedge i_clk);
    while ((rs | ~rw) && i_busy_indicator !== 1'b0 &&
           wait_cnt < 1000) begin
      @(negedge i_clk);
      wait_cnt++;
    end
    // a poll that runs out is a fault of the port, counted by the bench
    if ((rs | ~rw) && i_busy_indicator !== 1'b0) begin
      poll_fail++;
    end
    o_strobe = 1'b1;
    o_reg_choice_line = rs;
    o_read_not_write = rw;
    o_wdata = d;
    @(negedge i_clk);
    o_strobe = 1'b0;
    // released data lines show the inverse, never a stale byte
    o_wdata = ~d;
    rd_last = i_rdata;
  endtask : access

  // ==========================================================
  // one access launched at once, busy or not, to probe refusal
  task automatic access_now(input logic rs, input logic rw,
                            input logic [7:0] d);
    @(negedge i_clk);
    o_strobe = 1'b1;
    o_reg_choice_line = rs;
    o_read_not_write = rw;
    o_wdata = d;
    @(negedge i_clk);
    o_strobe = 1'b0;
    o_wdata = ~d;
    rd_last = i_rdata;
  endtask : access_now
endmodule : lcdhif_host_model

// file: lcd_host_register_interface_test.sv
// self-checking bench of the lcd host register port
// assumes lcdhif_top, lcdhif_mem and the host model are compiled first
`timescale 1ns/1ps
module lcd_host_register_interface_test;
  import lcdhif_pkg::*;
  logic clk = 1'b0; // 10 MHz
  logic rst_n = 1'b0; // held low for four cycles
  logic strap = 1'b1; // layout b
  logic strobe, rs, rw; // from the host model
  logic [7:0] wdata; // from the host model
  logic [7:0] rdata; // read data of the port
  logic busy; // busy indicator
  logic layout_b; // captured strap
  int err_total = 0;
  int tests_run = 0;

  // ==========================================================
  // clock and instances
  always #50 clk = ~clk;

  lcdhif_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_strobe(strobe),
    .i_reg_choice_line(rs), .i_read_not_write(rw), .i_wdata(wdata),
    .i_driver_order_strap(strap), .o_rdata(rdata),
    .o_busy_indicator(busy), .o_driver_layout_b(layout_b));

  lcdhif_host_model u_host (.i_clk(clk), .i_rdata(rdata),
    .i_busy_indicator(busy), .o_strobe(strobe),
    .o_reg_choice_line(rs), .o_read_not_write(rw), .o_wdata(wdata));

  // ==========================================================
  // compare and verdict
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic stop_test();
    // busy polls that ran out count as mismatches
    err_total += u_host.poll_fail;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // short forms of the four register operations
  task automatic cmd(input logic [7:0] d);
    u_host.access(1'b0, 1'b0, d);
  endtask : cmd
  task automatic wr(input logic [7:0] d);
    u_host.access(1'b1, 1'b0, d);
  endtask : wr
  task automatic rd_data(input logic [7:0] exp);
    u_host.access(1'b1, 1'b1, 8'h00);
    check8(u_host.rd_last, exp);
  endtask : rd_data
  task automatic rd_stat(input logic [7:0] exp);
    u_host.access(1'b0, 1'b1, 8'h00);
    check8(u_host.rd_last, exp);
  endtask : rd_stat

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check8({7'h00, layout_b}, 8'h01);
    check8(rdata, 8'h00);
    check8({7'h00, busy}, 8'h00);
  endtask : t_reset

  // writes drain to memory, address set and reads prefetch
  task automatic t_store_fetch();
    cmd(8'h85);
    wr(8'hA5);
    wr(8'h5A);
    rd_stat(8'h07);
    cmd(8'h85);
    rd_data(8'hA5);
    rd_data(8'h5A);
    // the prefetch after a read is still running two cycles later
    rd_stat(8'h87);
  endtask : t_store_fetch

  // the three memories keep separate bytes, glyph and char ones at like addresses
  task automatic t_mem_select();
    cmd(8'h43);
    wr(8'h3C);
    cmd(8'h22);
    wr(8'hC3);
    cmd(8'h83);
    wr(8'h11);
    cmd(8'h43);
    rd_data(8'h3C);
    cmd(8'h22);
    rd_data(8'hC3);
    cmd(8'h83);
    rd_data(8'h11);
  endtask : t_mem_select

  // long command shows busy; count down wraps below zero
  task automatic t_count_down();
    cmd(8'h04);
    rd_stat(8'h84);
    // a data write while busy is dropped: counter must not move
    u_host.access_now(1'b1, 1'b0, 8'hEE);
    rd_stat(8'h84);
    cmd(8'h80);
    wr(8'h77);
    rd_stat(8'h2F);
    cmd(8'h06);
    cmd(8'h80);
    rd_data(8'h77);
  endtask : t_count_down

  // a second reset with the strap low picks layout a, caught only once
  task automatic t_rerun_strap();
    @(negedge clk);
    strap = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check8(rdata, 8'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    strap = 1'b1;
    @(negedge clk);
    check8({7'h00, layout_b}, 8'h00);
    check8({7'h00, busy}, 8'h00);
    rd_stat(8'h00);
  endtask : t_rerun_strap

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_store_fetch();
    t_mem_select();
    t_count_down();
    t_rerun_strap();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : lcd_host_register_interface_test
